// >>> src/ocr_pin_decode.sv
// Decodes one output pin configuration byte into its control fields.
// Assumes the byte is the next-state value of a configuration register, ahead of its flop.
`timescale 1ns/1ps
module ocr_pin_decode
    import ocr_pkg::*;
(
    input wire logic [7:0] cfg,
    output ocr_pin_cfg_t pin
);
    always_comb begin
        pin.drive = ocr_drive_t'(cfg[OCR_DRV_HI:OCR_DRV_LO]);
        pin.level = cfg[OCR_LVL_HI:OCR_LVL_LO];
        // Reserved level code flagged so the analog stage can hold off
        pin.level_valid = (cfg[OCR_LVL_HI:OCR_LVL_LO] != OCR_LVL_RESERVED);
        pin.bypass_imp_20k = cfg[OCR_IMP_BIT];
    end
endmodule // ocr_pin_decode

// >>> src/ocr_pkg.sv
// Package for the output channel one configuration register bank.
// Assumes an 8-bit register address/data control port from the host interface.
package ocr_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OCR_POS_CFG_ADDR = 8'h65;
    localparam logic [7:0] OCR_NEG_CFG_ADDR = 8'h66;
    localparam logic [7:0] OCR_VOL_ADDR = 8'h67;
    // ----------------------------------------
    // Reset values and special codes
    // ----------------------------------------
    localparam logic [7:0] OCR_POS_CFG_RST = 8'h20;
    localparam logic [7:0] OCR_NEG_CFG_RST = 8'h20;
    localparam logic [7:0] OCR_VOL_RST = 8'hc9;
    localparam logic [7:0] OCR_VOL_MUTE = 8'h00;
    localparam logic [7:0] OCR_VOL_UNITY = 8'hc9;
    localparam logic [2:0] OCR_LVL_RESERVED = 3'h7;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int OCR_DRV_HI = 7;
    localparam int OCR_DRV_LO = 6;
    localparam int OCR_LVL_HI = 5;
    localparam int OCR_LVL_LO = 3;
    localparam int OCR_IMP_BIT = 2;
    localparam int OCR_BIT1 = 1;
    localparam int OCR_BIT0 = 0;
    // ----------------------------------------
    // Decoded field types
    // ----------------------------------------
    typedef enum logic [1:0] {
        OCR_DRV_LINE = 2'h0,
        OCR_DRV_HEADPHONE = 2'h1,
        OCR_DRV_FOUR_OHM = 2'h2,
        OCR_DRV_RECEIVER = 2'h3
    } ocr_drive_t;
    typedef struct packed {
        ocr_drive_t drive;
        logic [2:0] level;
        logic level_valid;
        logic bypass_imp_20k;
    } ocr_pin_cfg_t;
    typedef struct packed {
        logic bypass_single_ended;
        logic wide_bandwidth;
        logic full_scale_high;
        logic rail_to_rail;
        logic [7:0] volume_code;
        logic volume_mute;
        logic volume_unity;
    } ocr_dac_cfg_t;
endpackage

// >>> src/ocr_regs.sv
// Output channel one configuration register bank with host read/write port.
// Assumes a single-cycle host write strobe and a registered read answer.
//
// Operation
// [RQ1] Positive drive field bits 7-6, four types
// [RQ2] Negative drive field bits 7-6, same decode
// [RQ3] Positive level bits 5-3, reset 100b
// [RQ4] Negative level bits 5-3, reset 100b
// [RQ5] Software restricts level codes by path
// [RQ6] Bit 2 selects bypass impedance per input
// [RQ7] Bit 1 first register: bypass style
// [RQ8] Bit 0 first register: DAC bandwidth
// [RQ9] Bit 1 second register: full scale
// [RQ10] Software limits high full scale usage
// [RQ11] Bit 0 second register: coupling tolerance
// [RQ12] Volume code: mute, -100 dB, 0.5 steps
// [RQ13] Volume resets to 201, unity gain
// [RQ14] Fields read back last written value
`timescale 1ns/1ps
module ocr_regs
    import ocr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rvalid,
    output ocr_pin_cfg_t pos_pin,
    output ocr_pin_cfg_t neg_pin,
    output ocr_dac_cfg_t dac_cfg
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] pos_cfg_reg, pos_cfg_next;
    logic [7:0] neg_cfg_reg, neg_cfg_next;
    logic [7:0] vol_reg, vol_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    ocr_pin_cfg_t pos_pin_reg, pos_pin_next;
    ocr_pin_cfg_t neg_pin_reg, neg_pin_next;
    ocr_dac_cfg_t dac_reg, dac_next;
    ocr_pin_cfg_t pos_dec, neg_dec;

    always_comb begin
        pos_cfg_next = pos_cfg_reg;
        neg_cfg_next = neg_cfg_reg;
        vol_next = vol_reg;
        if (wr_en) begin
            unique case (addr)
                OCR_POS_CFG_ADDR: pos_cfg_next = wdata; // [RQ1] [RQ3] [RQ14]
                OCR_NEG_CFG_ADDR: neg_cfg_next = wdata; // [RQ2] [RQ4] [RQ14]
                OCR_VOL_ADDR: vol_next = wdata; // [RQ12] [RQ14]
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped addresses read as zero; read shows stored byte before same-cycle write
    always_comb begin
        rvalid_next = rd_en;
        rdata_next = 8'h00;
        if (rd_en) begin
            unique case (addr)
                OCR_POS_CFG_ADDR: rdata_next = pos_cfg_reg; // [RQ14]
                OCR_NEG_CFG_ADDR: rdata_next = neg_cfg_reg; // [RQ14]
                OCR_VOL_ADDR: rdata_next = vol_reg; // [RQ14]
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    ocr_pin_decode u_pos_dec (
        .cfg(pos_cfg_next),
        .pin(pos_dec)
    );
    ocr_pin_decode u_neg_dec (
        .cfg(neg_cfg_next),
        .pin(neg_dec)
    );

    always_comb begin
        pos_pin_next = pos_dec; // [RQ1] [RQ3] [RQ6]
        neg_pin_next = neg_dec; // [RQ2] [RQ4] [RQ6]
        dac_next.bypass_single_ended = pos_cfg_next[OCR_BIT1]; // [RQ7]
        dac_next.wide_bandwidth = pos_cfg_next[OCR_BIT0]; // [RQ8]
        dac_next.full_scale_high = neg_cfg_next[OCR_BIT1]; // [RQ9]
        dac_next.rail_to_rail = neg_cfg_next[OCR_BIT0]; // [RQ11]
        dac_next.volume_code = vol_next; // [RQ12]
        dac_next.volume_mute = (vol_next == OCR_VOL_MUTE); // [RQ12]
        dac_next.volume_unity = (vol_next == OCR_VOL_UNITY); // [RQ13]
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Decoded outputs registered alongside raw bytes so they track in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_cfg_reg <= OCR_POS_CFG_RST; // [RQ3]
            neg_cfg_reg <= OCR_NEG_CFG_RST; // [RQ4]
            vol_reg <= OCR_VOL_RST; // [RQ13]
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            pos_pin_reg.drive <= ocr_drive_t'(OCR_POS_CFG_RST[OCR_DRV_HI:OCR_DRV_LO]); // [RQ1]
            pos_pin_reg.level <= OCR_POS_CFG_RST[OCR_LVL_HI:OCR_LVL_LO]; // [RQ3]
            pos_pin_reg.level_valid <= (OCR_POS_CFG_RST[OCR_LVL_HI:OCR_LVL_LO] != OCR_LVL_RESERVED);
            pos_pin_reg.bypass_imp_20k <= OCR_POS_CFG_RST[OCR_IMP_BIT];
            neg_pin_reg.drive <= ocr_drive_t'(OCR_NEG_CFG_RST[OCR_DRV_HI:OCR_DRV_LO]); // [RQ2]
            neg_pin_reg.level <= OCR_NEG_CFG_RST[OCR_LVL_HI:OCR_LVL_LO]; // [RQ4]
            neg_pin_reg.level_valid <= (OCR_NEG_CFG_RST[OCR_LVL_HI:OCR_LVL_LO] != OCR_LVL_RESERVED);
            neg_pin_reg.bypass_imp_20k <= OCR_NEG_CFG_RST[OCR_IMP_BIT];
            dac_reg.bypass_single_ended <= OCR_POS_CFG_RST[OCR_BIT1];
            dac_reg.wide_bandwidth <= OCR_POS_CFG_RST[OCR_BIT0];
            dac_reg.full_scale_high <= OCR_NEG_CFG_RST[OCR_BIT1];
            dac_reg.rail_to_rail <= OCR_NEG_CFG_RST[OCR_BIT0];
            dac_reg.volume_code <= OCR_VOL_RST; // [RQ13]
            dac_reg.volume_mute <= (OCR_VOL_RST == OCR_VOL_MUTE);
            dac_reg.volume_unity <= (OCR_VOL_RST == OCR_VOL_UNITY);
        end else begin
            pos_cfg_reg <= pos_cfg_next;
            neg_cfg_reg <= neg_cfg_next;
            vol_reg <= vol_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            pos_pin_reg <= pos_pin_next;
            neg_pin_reg <= neg_pin_next;
            dac_reg <= dac_next;
        end
    end

    assign rdata = rdata_reg;
    assign rvalid = rvalid_reg;
    assign pos_pin = pos_pin_reg;
    assign neg_pin = neg_pin_reg;
    assign dac_cfg = dac_reg;

    // Strobes to addresses outside the bank
    logic addr_unmapped;
    assign addr_unmapped = (addr != OCR_POS_CFG_ADDR) && (addr != OCR_NEG_CFG_ADDR) && (addr != OCR_VOL_ADDR);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Write path: decoded fields follow the byte written
    pos_drive_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
        wr_en && addr == OCR_POS_CFG_ADDR
        |=> pos_pin.drive == ocr_drive_t'($past(wdata[OCR_DRV_HI:OCR_DRV_LO])))
        else $error("positive drive not updated");
    neg_drive_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> neg_pin.drive == ocr_drive_t'($past(wdata[OCR_DRV_HI:OCR_DRV_LO])))
        else $error("negative drive not updated");
    pos_level_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
        wr_en && addr == OCR_POS_CFG_ADDR |=> pos_pin.level == $past(wdata[OCR_LVL_HI:OCR_LVL_LO])
        && pos_pin.level_valid == ($past(wdata[OCR_LVL_HI:OCR_LVL_LO]) != OCR_LVL_RESERVED))
        else $error("positive level wrong");
    neg_level_a: assert property (@(posedge clk) disable iff (rst) // [RQ4]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> neg_pin.level == $past(wdata[OCR_LVL_HI:OCR_LVL_LO]))
        else $error("negative level wrong");
    neg_valid_a: assert property (@(posedge clk) disable iff (rst) // [RQ4]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> neg_pin.level_valid == ($past(wdata[OCR_LVL_HI:OCR_LVL_LO]) != OCR_LVL_RESERVED))
        else $error("negative level flag wrong");
    pos_imp_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        wr_en && addr == OCR_POS_CFG_ADDR
        |=> pos_pin.bypass_imp_20k == $past(wdata[OCR_IMP_BIT]))
        else $error("first register impedance not updated");
    neg_imp_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> neg_pin.bypass_imp_20k == $past(wdata[OCR_IMP_BIT]))
        else $error("second register impedance not updated");
    style_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ7]
        wr_en && addr == OCR_POS_CFG_ADDR
        |=> dac_cfg.bypass_single_ended == $past(wdata[OCR_BIT1]))
        else $error("bypass style not updated");
    bandwidth_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
        wr_en && addr == OCR_POS_CFG_ADDR
        |=> dac_cfg.wide_bandwidth == $past(wdata[OCR_BIT0]))
        else $error("bandwidth not updated");
    full_scale_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> dac_cfg.full_scale_high == $past(wdata[OCR_BIT1]))
        else $error("full scale not updated");
    coupling_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ11]
        wr_en && addr == OCR_NEG_CFG_ADDR
        |=> dac_cfg.rail_to_rail == $past(wdata[OCR_BIT0]))
        else $error("coupling tolerance not updated");
    volume_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
        wr_en && addr == OCR_VOL_ADDR
        |=> dac_cfg.volume_code == $past(wdata) && vol_reg == $past(wdata))
        else $error("volume code not updated");
    mute_write_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
        wr_en && addr == OCR_VOL_ADDR
        |=> dac_cfg.volume_mute == ($past(wdata) == OCR_VOL_MUTE))
        else $error("mute flag not updated");

    // ----------------------------------------
    // Assertions: outputs track stored bytes
    // ----------------------------------------
    // Decoded copies must never drift from the bytes read back
    bypass_imp_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        pos_pin.bypass_imp_20k == pos_cfg_reg[OCR_IMP_BIT]
        && neg_pin.bypass_imp_20k == neg_cfg_reg[OCR_IMP_BIT])
        else $error("bypass impedance mismatch");
    first_bits_a: assert property (@(posedge clk) disable iff (rst) // [RQ7] [RQ8]
        dac_cfg.bypass_single_ended == pos_cfg_reg[OCR_BIT1]
        && dac_cfg.wide_bandwidth == pos_cfg_reg[OCR_BIT0])
        else $error("first register low bits mismatch");
    second_bits_a: assert property (@(posedge clk) disable iff (rst) // [RQ9] [RQ11]
        dac_cfg.full_scale_high == neg_cfg_reg[OCR_BIT1]
        && dac_cfg.rail_to_rail == neg_cfg_reg[OCR_BIT0])
        else $error("second register low bits mismatch");
    volume_mute_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
        dac_cfg.volume_mute == (dac_cfg.volume_code == OCR_VOL_MUTE)
        && dac_cfg.volume_code == vol_reg)
        else $error("volume mute wrong");
    volume_unity_a: assert property (@(posedge clk) disable iff (rst) // [RQ13]
        dac_cfg.volume_unity == (dac_cfg.volume_code == OCR_VOL_UNITY))
        else $error("volume unity flag wrong");

    // ----------------------------------------
    // Assertions: reset values
    // ----------------------------------------
    // No disable here: these look at the edge right after a reset edge
    volume_reset_a: assert property (@(posedge clk) // [RQ13]
        $past(rst) |-> vol_reg == OCR_VOL_RST && dac_cfg.volume_code == OCR_VOL_RST
        && dac_cfg.volume_unity)
        else $error("volume reset not unity");
    reset_cfg_a: assert property (@(posedge clk) // [RQ3] [RQ4]
        $past(rst) |-> pos_cfg_reg == OCR_POS_CFG_RST && neg_cfg_reg == OCR_NEG_CFG_RST
        && !rvalid
        && rdata == 8'h00)
        else $error("register reset value wrong");
    reset_pins_a: assert property (@(posedge clk) // [RQ1] [RQ2]
        $past(rst) |-> pos_pin.drive == OCR_DRV_LINE && neg_pin.drive == OCR_DRV_LINE
        && pos_pin.level == OCR_POS_CFG_RST[OCR_LVL_HI:OCR_LVL_LO]
        && neg_pin.level == OCR_NEG_CFG_RST[OCR_LVL_HI:OCR_LVL_LO])
        else $error("pin reset value wrong");
    reset_dac_a: assert property (@(posedge clk) // [RQ7] [RQ8] [RQ9] [RQ11]
        $past(rst) |-> !dac_cfg.bypass_single_ended && !dac_cfg.wide_bandwidth
        && !dac_cfg.full_scale_high && !dac_cfg.rail_to_rail
        && !dac_cfg.volume_mute)
        else $error("converter reset value wrong");

    // ----------------------------------------
    // Assertions: host port
    // ----------------------------------------
    // Read answers come from the byte stored before the edge
    read_back_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        wr_en && !rd_en ##1 rd_en && !wr_en && addr == $past(addr) && addr == OCR_VOL_ADDR
        |=> rvalid
        && rdata == $past(wdata, 2))
        else $error("read back mismatch");
    pos_read_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        rd_en && addr == OCR_POS_CFG_ADDR
        |=> rvalid && rdata == $past(pos_cfg_reg))
        else $error("first register read wrong");
    neg_read_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        rd_en && addr == OCR_NEG_CFG_ADDR
        |=> rvalid && rdata == $past(neg_cfg_reg))
        else $error("second register read wrong");
    vol_read_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        rd_en && addr == OCR_VOL_ADDR
        |=> rvalid && rdata == $past(vol_reg))
        else $error("volume register read wrong");
    unmapped_read_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        rd_en && addr_unmapped
        |=> rvalid && rdata == 8'h00)
        else $error("unmapped read not zero");
    read_answer_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        rd_en |=> rvalid)
        else $error("read answer missing");
    read_pulse_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        !rd_en |=> !rvalid && rdata == 8'h00)
        else $error("read answer outside pulse");
    wr_unmapped_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        wr_en && addr_unmapped
        |=> $stable(pos_cfg_reg) && $stable(neg_cfg_reg) && $stable(vol_reg))
        else $error("unmapped write changed a register");
    // Hold checks skip reset: a reset edge may change any byte
    pos_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        !(wr_en && addr == OCR_POS_CFG_ADDR)
        |=> $stable(pos_cfg_reg))
        else $error("first register changed without write");
    neg_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        !(wr_en && addr == OCR_NEG_CFG_ADDR)
        |=> $stable(neg_cfg_reg))
        else $error("second register changed without write");
    vol_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
        !(wr_en && addr == OCR_VOL_ADDR)
        |=> $stable(vol_reg))
        else $error("volume register changed without write");
endmodule // ocr_regs

// >>> test/ocr_host_model.sv
// Host side model: byte writes and reads on the register port.
// Assumes the bench calls wr and rd by hierarchy, one at a time.
`timescale 1ns/1ps
module ocr_host_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // ----------------------------------------
    // Port cycles
    // ----------------------------------------
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // Path limits on level and full-scale codes stay with the caller
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        addr = ~a;  // Released lines never keep the old value
        wdata = ~d;
    endtask
    // Write, then read the same byte on the very next edge
    task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
        wdata = ~d;
        q = rdata;
        v = rvalid;
    endtask
    // Write and read in one cycle: the answer is the byte before the write
    task automatic wr_with_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
        @(negedge clk);
        wr_en = 1'b1;
        rd_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wdata = ~d;
        q = rdata;
        v = rvalid;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask
endmodule // ocr_host_model

// >>> test/tb.sv
// Self-checking bench for the output channel one register bank.
// Assumes the host model drives the port at the falling edge.
`timescale 1ns/1ps
module tb
    import ocr_pkg::*;
();
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en, rd_en, rvalid;
    logic [7:0] addr, wdata, rdata;
    ocr_pin_cfg_t pos_pin, neg_pin;
    ocr_dac_cfg_t dac_cfg;
    int mismatches = 0;
    int checked = 0;
    ocr_regs u_dut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid), .pos_pin(pos_pin), .neg_pin(neg_pin), .dac_cfg(dac_cfg));
    ocr_host_model u_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rvalid(rvalid));
    initial forever #12.5 clk = ~clk;
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_host.rd(a, d, v);
        chk1(v, 1'b1);
        chk8(d, exp);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(OCR_POS_CFG_ADDR, 8'h20);
        rd_chk(OCR_NEG_CFG_ADDR, 8'h20);
        rd_chk(OCR_VOL_ADDR, 8'hc9);
        chk1(dac_cfg.volume_unity, 1'b1);
    endtask
    task automatic t_drive();
        for (int i = 0; i < 4; i++) begin
            u_host.wr(OCR_POS_CFG_ADDR, {i[1:0], 6'h20});
            u_host.wr(OCR_NEG_CFG_ADDR, {~i[1:0], 6'h20});
            chk8({6'h00, pos_pin.drive}, {6'h00, i[1:0]});
            chk8({6'h00, neg_pin.drive}, {6'h00, ~i[1:0]});
        end
    endtask
    task automatic t_level();
        for (int i = 0; i < 8; i++) begin
            u_host.wr(OCR_POS_CFG_ADDR, {2'h0, i[2:0], 3'h0});
            u_host.wr(OCR_NEG_CFG_ADDR, {2'h3, i[2:0], 3'h7});
            chk8({5'h00, pos_pin.level}, {5'h00, i[2:0]});
            chk1(pos_pin.level_valid, i != 7);
            chk8({5'h00, neg_pin.level}, {5'h00, i[2:0]});
            chk1(neg_pin.level_valid, i != 7);
            rd_chk(OCR_NEG_CFG_ADDR, {2'h3, i[2:0], 3'h7});
        end
    endtask
    task automatic t_bits();
        logic [2:0] p;
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 3'h5 : 3'h2;
            u_host.wr(OCR_POS_CFG_ADDR, {5'h00, p});
            u_host.wr(OCR_NEG_CFG_ADDR, {5'h00, ~p});
            chk1(pos_pin.bypass_imp_20k, p[2]);
            chk1(dac_cfg.bypass_single_ended, p[1]);
            chk1(dac_cfg.wide_bandwidth, p[0]);
            chk1(neg_pin.bypass_imp_20k, ~p[2]);
            chk1(dac_cfg.full_scale_high, ~p[1]);
            chk1(dac_cfg.rail_to_rail, ~p[0]);
        end
    endtask
    task automatic t_volume();
        logic [7:0] codes[4] = '{8'h00, 8'h01, 8'hc9, 8'hff};
        foreach (codes[i]) begin
            u_host.wr(OCR_VOL_ADDR, codes[i]);
            chk8(dac_cfg.volume_code, codes[i]);
            chk1(dac_cfg.volume_mute, codes[i] == 8'h00);
            chk1(dac_cfg.volume_unity, codes[i] == 8'hc9);
            rd_chk(OCR_VOL_ADDR, codes[i]);
        end
    endtask
    task automatic t_unmapped();
        u_host.wr(8'h68, 8'h5a);
        rd_chk(8'h68, 8'h00);
        rd_chk(OCR_VOL_ADDR, 8'hff);
        rd_chk(OCR_POS_CFG_ADDR, 8'h02);
    endtask
    task automatic t_port();
        logic [7:0] q;
        logic v;
        u_host.wr_then_rd(OCR_VOL_ADDR, 8'h3c, q, v);
        chk1(v, 1'b1);
        chk8(q, 8'h3c);
        u_host.wr_with_rd(OCR_VOL_ADDR, 8'ha5, q, v);
        chk1(v, 1'b1);
        chk8(q, 8'h3c);
        @(negedge clk);
        chk1(rvalid, 1'b0);
        chk8(rdata, 8'h00);
        rd_chk(OCR_VOL_ADDR, 8'ha5);
    endtask
    task automatic t_rerun();
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk8({5'h00, pos_pin.level}, 8'h04);
        chk8({5'h00, neg_pin.level}, 8'h04);
        chk1(dac_cfg.bypass_single_ended, 1'b0);
        t_reset();
    endtask
    task automatic report_and_stop();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bound well above the roughly 120 cycles the scenarios need
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_drive();
        t_level();
        t_bits();
        t_volume();
        t_unmapped();
        t_port();
        t_rerun();
        report_and_stop();
    end
endmodule // tb
